// ### hw/sacfc_ctrl.sv
/*
 * Sequencer of a 12-bit successive-approximation converter: conversion
 * clock derivation, acquisition and conversion timing, power, Sleep and
 * Idle handling, result storage and formatted read-back.
 * Assumes core_clk_i is the instruction clock, that cpu_sleep_i, cpu_idle_i,
 * the configuration and the strobes come from logic on that clock, and
 * that the RC oscillator and the analog result arrive asynchronously.
 */

`timescale 1ns/10ps
`include "sacfc_consts.svh"

module sacfc_ctrl
    import sacfc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire sacfc_cfg_t cfg_i,
    input wire logic cpu_sleep_i,
    input wire logic cpu_idle_i,
    input wire logic irq_enable_i,
    input wire logic sample_set_i,
    input wire logic sample_clear_i,
    input wire logic ext_trigger_i,
    input wire logic done_clear_i,
    input wire logic rc_osc_i,
    input wire logic [`SACFC_RES_W-1:0] conv_data_i,
    input wire logic wr_en_i,
    input wire logic [`SACFC_BUF_AW-1:0] wr_addr_i,
    input wire logic [`SACFC_WORD_W-1:0] wr_data_i,
    input wire logic [`SACFC_BUF_AW-1:0] rd_addr_i,
    output logic [`SACFC_WORD_W-1:0] rd_data_o,
    output logic sample_active_o,
    output logic conv_busy_o,
    output logic done_o,
    output logic conv_irq_o,
    output logic wake_o,
    output logic analog_on_o,
    output logic conv_clk_o,
    output logic [`SACFC_BUF_AW-1:0] wr_ptr_o
);

    localparam int DEPTH = 1 << `SACFC_BUF_AW;

    sacfc_regs_t cur_reg;
    sacfc_regs_t cur_next;

    // The result memory has no reset so a device reset leaves it intact.
    logic [`SACFC_RES_W-1:0] result_buffer [DEPTH];

    logic mem_we;
    logic [`SACFC_BUF_AW-1:0] mem_waddr;
    logic [`SACFC_RES_W-1:0] mem_wdata;
    logic [`SACFC_WORD_W-1:0] fmt_word;
    logic rc_edge;
    logic clk_stop;
    logic halted;
    logic tad_tick;
    logic trig;
    logic finish;
    logic [6:0] div_n;
    logic [6:0] acc;
    logic [5:0] acq_target;

    sacfc_fmt u_fmt (
        .raw_i(result_buffer[rd_addr_i]),
        .fmt_i(cfg_i.output_format_sel),
        .word_o(fmt_word)
    );

    always_comb begin
        cur_next = cur_reg;
        cur_next.irq = 1'b0;
        cur_next.wake = 1'b0;
        mem_we = 1'b0;
        mem_waddr = wr_addr_i;
        mem_wdata = wr_data_i[`SACFC_RES_W-1:0];
        trig = 1'b0;
        finish = 1'b0;
        tad_tick = 1'b0;
        acc = 7'h00;

        cur_next.rc_sync = {cur_reg.rc_sync[0], rc_osc_i};
        cur_next.rc_prev = cur_reg.rc_sync[1];
        // The result word is synchronised bit by bit with no handshake, so it must
        // hold still for the last periods of a conversion or a torn code is stored.
        cur_next.conv_s0 = conv_data_i;
        cur_next.conv_s1 = cur_reg.conv_s0;
        rc_edge = cur_reg.rc_sync[1] & ~cur_reg.rc_prev;

        // Without the RC source every module clock is gone during Sleep.
        clk_stop = cpu_sleep_i & ~cfg_i.rc_clock_select;
        halted = clk_stop | (cpu_idle_i & cfg_i.stop_in_idle) | cur_reg.slept_off;

        // The divider counts half instruction cycles; an even setting gives
        // an odd half count, so single periods jitter by half a cycle while
        // the average period is exact. A setting of zero cannot run faster
        // than one period per cycle.
        div_n = {1'b0, cfg_i.conv_clk_divider} + 7'h01;
        if (cfg_i.rc_clock_select) begin
            tad_tick = rc_edge;
            cur_next.half_acc = 7'h00;
        end else begin
            acc = cur_reg.half_acc + `SACFC_HALF_STEP;
            if (acc >= div_n) begin
                tad_tick = 1'b1;
                acc = acc - div_n;
                if (acc >= div_n) begin
                    acc = 7'h00;
                end
            end
            cur_next.half_acc = acc;
        end
        if (halted || cur_reg.st == SACFC_OFF) begin
            tad_tick = 1'b0;
            cur_next.half_acc = cur_reg.half_acc;
        end
        if (tad_tick) begin
            cur_next.conv_clk = ~cur_reg.conv_clk;
        end

        // A zero acquisition setting is stretched to the shortest legal hold.
        if (cfg_i.auto_acq_time == 5'h00) begin
            acq_target = {1'b0, `SACFC_MIN_ACQ};
        end else begin
            acq_target = {1'b0, cfg_i.auto_acq_time};
        end

        if (!cpu_sleep_i) begin
            cur_next.slept_off = 1'b0;
        end
        if (done_clear_i) begin
            cur_next.done = 1'b0;
        end

        if (!halted) begin
            case (cur_reg.st)
                SACFC_OFF: begin
                    if (cfg_i.module_on) begin
                        cur_next.st = SACFC_IDLE;
                    end
                end
                SACFC_IDLE: begin
                    if (sample_set_i || cfg_i.auto_sample_en) begin
                        cur_next.st = SACFC_SAMPLE;
                        cur_next.acq_cnt = 5'h00;
                    end
                end
                SACFC_SAMPLE: begin
                    if (tad_tick) begin
                        cur_next.acq_cnt = cur_reg.acq_cnt + 5'h01;
                    end
                    case (cfg_i.trigger_source_sel)
                        `SACFC_TRIG_MANUAL: trig = sample_clear_i;
                        `SACFC_TRIG_AUTO:
                            trig = tad_tick && ({1'b0, cur_reg.acq_cnt} + 6'h01 >= acq_target);
                        default: trig = ext_trigger_i;
                    endcase
                    if (trig) begin
                        cur_next.tad_cnt = 4'h0;
                        if (cfg_i.rc_clock_select) begin
                            cur_next.st = SACFC_DELAY;
                        end else begin
                            cur_next.st = SACFC_CONVERT;
                        end
                    end
                end
                SACFC_DELAY: begin
                    cur_next.st = SACFC_CONVERT;
                end
                SACFC_CONVERT: begin
                    if (tad_tick) begin
                        cur_next.tad_cnt = cur_reg.tad_cnt + 4'h1;
                        if (cur_reg.tad_cnt == `SACFC_CONV_TADS) begin
                            finish = 1'b1;
                        end
                    end
                end
                default: begin
                    cur_next.st = SACFC_OFF;
                end
            endcase
        end

        if (finish) begin
            mem_we = 1'b1;
            mem_waddr = cur_reg.wr_ptr;
            mem_wdata = cur_reg.conv_s1;
            cur_next.wr_ptr = cur_reg.wr_ptr + 4'h1;
            cur_next.smp_cnt = cur_reg.smp_cnt + 4'h1;
            if (cfg_i.auto_sample_en) begin
                cur_next.st = SACFC_SAMPLE;
                cur_next.acq_cnt = 5'h00;
            end else begin
                cur_next.st = SACFC_IDLE;
            end
            if (cur_reg.smp_cnt == cfg_i.samples_per_irq) begin
                cur_next.smp_cnt = 4'h0;
                cur_next.wr_ptr = 4'h0;
                cur_next.done = 1'b1;
                cur_next.irq = 1'b1;
            end
            if (cpu_sleep_i) begin
                if (irq_enable_i) begin
                    cur_next.wake = cur_reg.smp_cnt == cfg_i.samples_per_irq;
                end else begin
                    cur_next.slept_off = 1'b1;
                end
            end
        end

        // Entering Sleep on the instruction clock drops a conversion under way.
        if (clk_stop && (cur_reg.st == SACFC_DELAY || cur_reg.st == SACFC_CONVERT)) begin
            cur_next.st = SACFC_IDLE;
            cur_next.tad_cnt = 4'h0;
        end
        if (clk_stop) begin
            cur_next.conv_clk = 1'b0;
        end

        // Switching off wins over any restart and discards a partial result.
        if (!cfg_i.module_on) begin
            cur_next.st = SACFC_OFF;
            cur_next.tad_cnt = 4'h0;
            cur_next.acq_cnt = 5'h00;
            cur_next.smp_cnt = 4'h0;
            cur_next.wr_ptr = 4'h0;
            cur_next.half_acc = 7'h00;
            cur_next.conv_clk = 1'b0;
            cur_next.slept_off = 1'b0;
            cur_next.irq = 1'b0;
            cur_next.wake = 1'b0;
            if (finish) begin
                cur_next.done = cur_reg.done & ~done_clear_i;
            end
            mem_we = 1'b0;
            mem_waddr = wr_addr_i;
            mem_wdata = wr_data_i[`SACFC_RES_W-1:0];
        end

        // A software store only lands when no conversion result is written.
        if (!mem_we && wr_en_i) begin
            mem_we = 1'b1;
        end

        cur_next.rd_data = fmt_word;
    end

    // Configuration lives outside this block, so Sleep leaves it unchanged.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (mem_we) begin
            result_buffer[mem_waddr] <= mem_wdata;
        end
    end

    assign rd_data_o = cur_reg.rd_data;
    assign sample_active_o = cur_reg.st == SACFC_SAMPLE;
    assign conv_busy_o = cur_reg.st == SACFC_DELAY || cur_reg.st == SACFC_CONVERT;
    assign done_o = cur_reg.done;
    assign conv_irq_o = cur_reg.irq;
    assign wake_o = cur_reg.wake;
    assign analog_on_o = cur_reg.st != SACFC_OFF && !cur_reg.slept_off;
    assign conv_clk_o = cur_reg.conv_clk;
    assign wr_ptr_o = cur_reg.wr_ptr;

endmodule

// ### hw/sacfc_consts.svh
/*
 * Constants of the converter control block: trigger codes, format codes,
 * conversion length and buffer geometry.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef SACFC_CONSTS_SVH
`define SACFC_CONSTS_SVH

`define SACFC_CLK_PERIOD_NS 8
`define SACFC_CONV_TADS 4'hd
`define SACFC_TRIG_MANUAL 3'h0
`define SACFC_TRIG_AUTO 3'h7
`define SACFC_FMT_INT 2'h0
`define SACFC_FMT_SINT 2'h1
`define SACFC_FMT_FRAC 2'h2
`define SACFC_FMT_SFRAC 2'h3
`define SACFC_MIN_ACQ 5'h01
`define SACFC_HALF_STEP 7'h02
`define SACFC_BUF_AW 4
`define SACFC_RES_W 12
`define SACFC_WORD_W 16

`endif

// ### hw/sacfc_pkg.sv
/*
 * Types of the converter control block: state encoding, configuration
 * carrier and the packed state of the controller.
 * Assumes the constants header is on the include path.
 */
`include "sacfc_consts.svh"

package sacfc_pkg;

    typedef enum logic [2:0] {
        SACFC_OFF,
        SACFC_IDLE,
        SACFC_SAMPLE,
        SACFC_DELAY,
        SACFC_CONVERT
    } sacfc_state_t;

    typedef struct packed {
        logic module_on;
        logic stop_in_idle;
        logic rc_clock_select;
        logic [5:0] conv_clk_divider;
        logic [2:0] trigger_source_sel;
        logic auto_sample_en;
        logic [3:0] samples_per_irq;
        logic [4:0] auto_acq_time;
        logic [1:0] output_format_sel;
    } sacfc_cfg_t;

    typedef struct packed {
        sacfc_state_t st;
        logic [6:0] half_acc;
        logic [4:0] acq_cnt;
        logic [3:0] tad_cnt;
        logic [`SACFC_BUF_AW-1:0] wr_ptr;
        logic [3:0] smp_cnt;
        logic done;
        logic irq;
        logic wake;
        logic slept_off;
        logic conv_clk;
        logic [1:0] rc_sync;
        logic rc_prev;
        logic [`SACFC_RES_W-1:0] conv_s0;
        logic [`SACFC_RES_W-1:0] conv_s1;
        logic [`SACFC_WORD_W-1:0] rd_data;
    } sacfc_regs_t;

endpackage

// ### hw/sacfc_fmt.sv
/*
 * Result formatter: turns a stored 12-bit right-justified sample into one
 * of three 16-bit read layouts; both fractional codes give the same one.
 * Assumes a purely combinational use by the controller, which registers it.
 */
`timescale 1ns/10ps
`include "sacfc_consts.svh"

module sacfc_fmt
    import sacfc_pkg::*;
(
    input wire logic [`SACFC_RES_W-1:0] raw_i,
    input wire logic [1:0] fmt_i,
    output logic [`SACFC_WORD_W-1:0] word_o
);

    function automatic logic [`SACFC_WORD_W-1:0] sacfc_layout(
        input logic [`SACFC_RES_W-1:0] raw,
        input logic [1:0] fmt
    );
        logic [`SACFC_WORD_W-1:0] w;
        w = {4'h0, raw};
        case (fmt)
            `SACFC_FMT_INT: w = {4'h0, raw};
            `SACFC_FMT_SINT: w = {{4{raw[11]}}, raw};
            `SACFC_FMT_FRAC: w = {raw, 4'h0};
            `SACFC_FMT_SFRAC: w = {raw, 4'h0};
            default: w = {4'h0, raw};
        endcase
        return w;
    endfunction

    // The encoding of the two format bits follows the header constants.
    always_comb begin
        word_o = sacfc_layout(raw_i, fmt_i);
    end

endmodule

// ### verification/sacfc_ctrl_props.sv
/*
 * Port-level checks of the converter sequencer.
 * Assumes binding to sacfc_ctrl with everything on core_clk_i.
 */
`timescale 1ns/10ps
`include "sacfc_consts.svh"
module sacfc_ctrl_props
    import sacfc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire sacfc_cfg_t cfg_i,
    input wire logic cpu_sleep_i,
    input wire logic cpu_idle_i,
    input wire logic irq_enable_i,
    input wire logic done_clear_i,
    input wire logic sample_active_o,
    input wire logic conv_busy_o,
    input wire logic done_o,
    input wire logic conv_irq_o,
    input wire logic wake_o,
    input wire logic analog_on_o,
    input wire logic conv_clk_o,
    input wire logic [`SACFC_BUF_AW-1:0] wr_ptr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_off;
        !cfg_i.module_on |=> !conv_busy_o && !sample_active_o && !analog_on_o;
    endproperty
    a_off: assert property (p_off) else $error("module off but active");
    property p_irq_done;
        conv_irq_o |-> done_o;
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("irq without done");
    property p_irq_pulse;
        conv_irq_o |=> !conv_irq_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    property p_irq_ptr;
        conv_irq_o |-> wr_ptr_o == 4'h0;
    endproperty
    a_irq_ptr: assert property (p_irq_ptr) else $error("pointer not wrapped at irq");
    property p_sleep_clk;
        (cpu_sleep_i && !cfg_i.rc_clock_select) [*2] |-> !conv_clk_o;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");
    property p_sleep_abort;
        cpu_sleep_i && !cfg_i.rc_clock_select && conv_busy_o |-> ##[1:2] !conv_busy_o;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");
    property p_conv_len;
        $rose(conv_busy_o) |-> (conv_busy_o || !cfg_i.module_on || cpu_sleep_i) [*8];
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion too short");
    property p_wake;
        wake_o |-> $past(irq_enable_i) && cpu_sleep_i;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without enable");
    property p_done_hold;
        done_o && !done_clear_i |=> done_o;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_idle;
        cpu_idle_i && cfg_i.stop_in_idle && !sample_active_o |=> !sample_active_o;
    endproperty
    a_idle: assert property (p_idle) else $error("sampling started in idle");
endmodule
bind sacfc_ctrl sacfc_ctrl_props props_u (.core_clk_i, .rst_n_i, .cfg_i, .cpu_sleep_i,
    .cpu_idle_i, .irq_enable_i, .done_clear_i, .sample_active_o, .conv_busy_o, .done_o,
    .conv_irq_o, .wake_o, .analog_on_o, .conv_clk_o, .wr_ptr_o);

// ### verification/sacfc_analog_model.sv
/*
 * Analog side: RC oscillator and converter result.
 * Assumes the bench enables the oscillator only when it is selected.
 */
`timescale 1ns/10ps
module sacfc_analog_model (
    input wire logic run_i,
    input wire logic [11:0] code_i,
    output logic rc_osc_o,
    output logic [11:0] data_o
);
    initial rc_osc_o = 1'b0;
    // The oscillator stands still when off, so no stray period ticks reach the design.
    // Edges fall on the core clock's falling edges, and a 336 ns period keeps the
    // RC conversion period above the analog minimum.
    always #168 rc_osc_o = run_i ? ~rc_osc_o : 1'b0;
    assign data_o = code_i;
endmodule

// ### verification/sacfc_ctrl_tb_top.sv
/*
 * Directed bench of the converter sequencer.
 * Assumes the analog model and the bound checker are compiled alongside.
 */
`timescale 1ns/10ps
`include "sacfc_consts.svh"
module sacfc_ctrl_tb_top
    import sacfc_pkg::*;
;
    localparam int CONVP = 32'he;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    sacfc_cfg_t cfg = '0;
    logic sleep = 1'b0, idle = 1'b0, irq_en = 1'b0, rc_run = 1'b0, wr_en = 1'b0;
    logic [2:0] stb = 3'h0;
    logic [11:0] code = 12'h3c7;
    logic [11:0] adata;
    logic [3:0] rd_addr = 4'h0;
    logic [3:0] wptr;
    logic [15:0] rd_data;
    logic [15:0] fx [4] = '{16'h08a5, 16'hf8a5, 16'h8a50, 16'h8a50};
    logic sact, busy, done, irq, wake, aon, cclk, rc_osc;
    int err_total = 0, check_count = 0, n, m, k;
    always #4 core_clk_i = ~core_clk_i;
    sacfc_analog_model model_u (.run_i(rc_run), .code_i(code), .rc_osc_o(rc_osc),
        .data_o(adata));
    sacfc_ctrl dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
        .cpu_sleep_i(sleep), .cpu_idle_i(idle), .irq_enable_i(irq_en),
        .sample_set_i(stb[0]), .sample_clear_i(stb[1]), .ext_trigger_i(1'b0),
        .done_clear_i(stb[2]), .rc_osc_i(rc_osc), .conv_data_i(adata), .wr_en_i(wr_en),
        .wr_addr_i(4'h3), .wr_data_i(16'hf8a5), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
        .sample_active_o(sact), .conv_busy_o(busy), .done_o(done), .conv_irq_o(irq),
        .wake_o(wake), .analog_on_o(aon), .conv_clk_o(cclk), .wr_ptr_o(wptr));
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int c);
        repeat (c) @(negedge core_clk_i);
    endtask
    // A leading edge keeps one strobe from being lowered and raised in one step.
    task pulse(input logic [2:0] v);
        tick(1);
        stb = v;
        tick(1);
        stb = 3'h0;
    endtask
    // Bounded so that a stuck sequencer ends the run instead of hanging it.
    task await(input logic [1:0] s, input logic lvl);
        n = 0;
        while (((s == 2'h0) ? busy : (s == 2'h1) ? wake : done) !== lvl) begin
            tick(1);
            n++;
            if (n > 2000) begin
                err_total++;
                wrap_up();
            end
        end
    endtask
    task rd(input logic [3:0] a, input logic [1:0] f, input logic [15:0] e);
        rd_addr = a;
        cfg.output_format_sel = f;
        tick(2);
        chk(rd_data, e);
    endtask
    task restart;
        cfg.module_on = 1'b0;
        tick(2);
        cfg.module_on = 1'b1;
        tick(2);
        pulse(3'h4);
    endtask
    task convs;
        k = 0;
        do begin
            await(2'h0, 1'b1);
            await(2'h0, 1'b0);
            k++;
        end while (done !== 1'b1 && k < 9);
    endtask
    initial begin
        tick(6);
        rst_n_i = 1'b1;
        tick(1);
        chk(16'({done, busy, aon, sact}), 16'h0);
        cfg.conv_clk_divider = 6'h01;
        restart();
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        for (int f = 0; f < 4; f++) rd(4'h3, 2'(f), fx[f]);
        pulse(3'h1);
        chk(16'(sact), 16'h1);
        pulse(3'h2);
        await(2'h0, 1'b1);
        await(2'h0, 1'b0);
        chk(16'(n), 16'(CONVP));
        chk(16'(done), 16'h1);
        rd(4'h0, 2'h0, {4'h0, code});
        cfg.trigger_source_sel = 3'h7;
        cfg.auto_sample_en = 1'b1;
        cfg.auto_acq_time = 5'h01;
        cfg.samples_per_irq = 4'h1;
        for (int d = 1; d < 4; d += 2) begin
            cfg.conv_clk_divider = 6'(d);
            restart();
            convs();
            pulse(3'h4);
            convs();
            chk(16'(k), 16'h2);
            await(2'h0, 1'b1);
            await(2'h0, 1'b0);
            m = n;
            await(2'h0, 1'b1);
            chk(16'(m + n), 16'((CONVP + 1) * ((d + 1) >> 1)));
        end
        cfg = '0;
        cfg.conv_clk_divider = 6'h3f;
        restart();
        code = 12'h111;
        pulse(3'h1);
        pulse(3'h2);
        await(2'h0, 1'b1);
        tick(8);
        sleep = 1'b1;
        tick(3);
        chk(16'(busy), 16'h0);
        sleep = 1'b0;
        tick(600);
        chk(16'(done), 16'h0);
        rd(4'h0, 2'h0, 16'h03c7);
        // Reset in mid-conversion returns control to off and leaves the stored word.
        pulse(3'h1);
        pulse(3'h2);
        tick(4);
        chk(16'(busy), 16'h1);
        rst_n_i = 1'b0;
        tick(2);
        chk(16'({done, busy, aon, sact}), 16'h0);
        rst_n_i = 1'b1;
        rd(4'h0, 2'h0, 16'h03c7);
        cfg.rc_clock_select = 1'b1;
        rc_run = 1'b1;
        for (int w = 1; w >= 0; w--) begin
            irq_en = 1'(w);
            restart();
            pulse(3'h1);
            pulse(3'h2);
            sleep = 1'b1;
            await(2'h2, 1'b1);
            chk(16'(wake), 16'(w));
            tick(2);
            chk(16'(aon), 16'(w));
            sleep = 1'b0;
            tick(2);
            chk(16'(aon), 16'h1);
        end
        await(2'h1, 1'b0);
        cfg.rc_clock_select = 1'b0;
        rc_run = 1'b0;
        cfg.stop_in_idle = 1'b1;
        restart();
        idle = 1'b1;
        pulse(3'h1);
        chk(16'(sact), 16'h0);
        cfg.stop_in_idle = 1'b0;
        pulse(3'h1);
        chk(16'(sact), 16'h1);
        idle = 1'b0;
        wrap_up();
    end
endmodule
